// >>> refresh_timer.v
`timescale 1ns/1ps
`include "sdram_pins_consts.vh"
module refresh_timer #(
    parameter [15:0] INTERVAL = `REFRESH_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire taken,
    output reg pending
);
    reg [15:0] count;
    // ==========================================================
    // interval counter; request stays set until served
    always @(posedge clk) begin
        if (sys_rst) begin
            count <= 16'h0000;
            pending <= 1'b0;
        end else begin
            if (count >= INTERVAL - 16'h0001) begin
                count <= 16'h0000;
                pending <= 1'b1;
            end else begin
                count <= count + 16'h0001;
                if (taken) begin
                    pending <= 1'b0;
                end
            end
        end
    end
endmodule // refresh_timer

// >>> sdram_array_model.sv
`timescale 1ns/1ps
module sdram_array_model (
    input wire clk,
    input wire sdram_ras_n,
    input wire sdram_cas_n,
    input wire sdram_write_enable_n,
    input wire sdram_ctl_oe_n,
    output reg [15:0] n_refresh,
    output reg [15:0] n_write
);
initial begin
    n_refresh = 16'h0;
    n_write = 16'h0;
end
// ==========================================================
// command decode; nothing counts while the pins are released
always @(posedge clk) begin
    if (!sdram_ctl_oe_n && !sdram_ras_n && !sdram_cas_n && sdram_write_enable_n)
        n_refresh <= n_refresh + 16'h1;
    if (!sdram_ctl_oe_n && sdram_ras_n && !sdram_cas_n && !sdram_write_enable_n)
        n_write <= n_write + 16'h1;
end
endmodule // sdram_array_model

// >>> sdram_pin_interface.v
`timescale 1ns/1ps
`include "sdram_pins_consts.vh"
module sdram_pin_interface #(
    parameter [15:0] REFRESH_INTERVAL = `REFRESH_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire req_valid,
    input wire req_write,
    input wire req_single,
    input wire [31:0] req_addr,
    input wire bus32_mode,
    input wire is_master,
    input wire suspend_req,
    input wire host_bus_request_n,
    input wire other_addr_busy,
    output reg req_ready,
    output reg [3:0] sdram_bank_select_n,
    output reg [3:0] sdram_bank_select_oe_n,
    output reg sdram_ras_n,
    output reg sdram_cas_n,
    output reg sdram_write_enable_n,
    output reg sdram_ctl_oe_n,
    output reg [13:0] sdram_addr,
    output reg sdram_addr_bit10,
    output reg low_word_mask,
    output reg high_word_mask,
    output reg sdram_clock_enable,
    output reg host_bus_grant,
    output reg self_refresh
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ACT = 4'h1;
    localparam [3:0] S_RW = 4'h2;
    localparam [3:0] S_PRE = 4'h3;
    localparam [3:0] S_REF = 4'h4;
    localparam [3:0] S_SREF = 4'h5;
    localparam [3:0] S_GRANT = 4'h6;
    localparam [3:0] S_SUSP = 4'h7;
    localparam [3:0] S_EXIT = 4'h8;

    reg [3:0] state;
    reg hbr_meta;
    reg hbr_sync;
    reg [31:0] addr_q;
    reg write_q;
    reg single_q;
    reg refresh_taken;
    wire refresh_pending;
    wire in_region;
    reg [2:0] next_cmd;

    // ==========================================================
    // pin synchroniser for the host request
    always @(posedge clk) begin
        if (sys_rst) begin
            hbr_meta <= 1'b1;
            hbr_sync <= 1'b1;
        end else begin
            hbr_meta <= host_bus_request_n;
            hbr_sync <= hbr_meta;
        end
    end

    refresh_timer #(
        .INTERVAL(REFRESH_INTERVAL)
    ) u_refresh (
        .clk(clk),
        .sys_rst(sys_rst),
        .taken(refresh_taken),
        .pending(refresh_pending)
    );

    // reserved space taken as the upper half of each bank slice, where bit 27 is set
    assign in_region = (req_addr[31:30] == `SDRAM_REGION) && !req_addr[`RESERVED_MSB];

    // ==========================================================
    // command encode
    always @* begin
        case (state)
            S_ACT: next_cmd = `CMD_ACTIVE;
            S_RW: next_cmd = write_q ? `CMD_WRITE : `CMD_READ;
            S_PRE: next_cmd = `CMD_PRECHARGE;
            S_REF: next_cmd = `CMD_REFRESH;
            S_SREF: next_cmd = `CMD_REFRESH;
            default: next_cmd = `CMD_NOP;
        endcase
    end

    // ==========================================================
    // sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= S_IDLE;
            addr_q <= 32'h00000000;
            write_q <= 1'b0;
            single_q <= 1'b0;
            refresh_taken <= 1'b0;
            req_ready <= 1'b0;
            host_bus_grant <= 1'b0;
            self_refresh <= 1'b0;
            sdram_clock_enable <= 1'b1;
        end else begin
            refresh_taken <= 1'b0;
            req_ready <= 1'b0;
            case (state)
                S_IDLE: begin
                    // refresh first so a busy port cannot starve it
                    if (refresh_pending && !refresh_taken) begin
                        state <= S_REF;
                        refresh_taken <= 1'b1;
                    end else if (!hbr_sync && is_master) begin
                        state <= S_SREF;
                    end else if (suspend_req) begin
                        state <= S_SUSP;
                        sdram_clock_enable <= 1'b0;
                    end else if (req_valid && in_region && is_master) begin
                        addr_q <= req_addr;
                        write_q <= req_write;
                        single_q <= req_single;
                        state <= S_ACT;
                    end
                end
                S_ACT: state <= S_RW;
                S_RW: begin
                    req_ready <= 1'b1;
                    state <= S_PRE;
                end
                S_PRE: state <= S_IDLE;
                S_REF: state <= S_IDLE;
                S_SREF: begin
                    sdram_clock_enable <= 1'b0;
                    self_refresh <= 1'b1;
                    host_bus_grant <= 1'b1;
                    state <= S_GRANT;
                end
                S_GRANT: begin
                    if (hbr_sync) begin
                        host_bus_grant <= 1'b0;
                        state <= S_EXIT;
                    end
                end
                S_SUSP: begin
                    if (!suspend_req) begin
                        sdram_clock_enable <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_EXIT: begin
                    sdram_clock_enable <= 1'b1;
                    self_refresh <= 1'b0;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pin registers
    always @(posedge clk) begin
        if (sys_rst) begin
            sdram_bank_select_n <= 4'hF;
            sdram_bank_select_oe_n <= 4'hF;
            sdram_ras_n <= 1'b1;
            sdram_cas_n <= 1'b1;
            sdram_write_enable_n <= 1'b1;
            sdram_ctl_oe_n <= 1'b1;
            sdram_addr <= 14'h0000;
            sdram_addr_bit10 <= 1'b0;
            low_word_mask <= 1'b0;
            high_word_mask <= 1'b0;
        end else begin
            sdram_ras_n <= next_cmd[2];
            sdram_cas_n <= next_cmd[1];
            sdram_write_enable_n <= next_cmd[0];
            // released when not master or while the host owns the bus
            sdram_ctl_oe_n <= !is_master || state == S_GRANT || state == S_EXIT;
            sdram_bank_select_oe_n <= (!is_master || state == S_GRANT || state == S_EXIT)
                ? 4'hF : 4'h0;
            sdram_bank_select_n <= 4'hF;
            if (state == S_ACT || state == S_RW || state == S_PRE) begin
                sdram_bank_select_n <= ~(4'h1 << addr_q[`BANK_SEL_MSB:`BANK_SEL_LSB]);
            end else if (state == S_REF || state == S_SREF) begin
                sdram_bank_select_n <= 4'h0;
            end
            if (state == S_ACT) begin
                sdram_addr <= addr_q[26:13];
            end else if (state == S_RW) begin
                sdram_addr <= {4'h0, addr_q[12:3]};
            end
            // bit 10 drives precharge-all; refresh needs no main address lines
            if (state == S_ACT) begin
                sdram_addr_bit10 <= addr_q[23];
            end else begin
                sdram_addr_bit10 <= (state == S_PRE);
            end
            low_word_mask <= 1'b0;
            high_word_mask <= 1'b0;
            if (state == S_RW && write_q) begin
                low_word_mask <= !bus32_mode && addr_q[2];
                high_word_mask <= bus32_mode || (single_q && !addr_q[2]);
            end
        end
    end
endmodule // sdram_pin_interface

// >>> sdram_pin_interface_test.sv
`timescale 1ns/1ps
module sdram_pin_interface_test;
reg clk = 1'h0, sys_rst = 1'h1, req_valid = 1'h0, req_write = 1'h0, req_single = 1'h0;
reg bus32_mode = 1'h0, is_master = 1'h1, suspend_req = 1'h0, host_bus_request_n = 1'h1;
reg other_addr_busy = 1'h0;
reg [31:0] req_addr = 32'h0;
wire req_ready, sdram_ras_n, sdram_cas_n, sdram_write_enable_n, sdram_ctl_oe_n;
wire sdram_addr_bit10, low_word_mask, high_word_mask, sdram_clock_enable;
wire host_bus_grant, self_refresh;
wire [3:0] sdram_bank_select_n, sdram_bank_select_oe_n;
wire [13:0] sdram_addr;
wire [15:0] n_refresh, n_write;
wire [3:0] watch = {req_ready, host_bus_grant, sdram_clock_enable, self_refresh};
integer n_errors = 0, comparisons = 0, i, k;
reg seen;
// short refresh interval keeps the run brief
sdram_pin_interface #(.REFRESH_INTERVAL(16'h0014)) sdram_pin_interface_i (.*);
sdram_array_model sdram_array_model_i (.*);
initial begin
    forever #2.5 clk = ~clk;
end
// ==========================================================
// shared tasks
task chk(input [31:0] got, input [31:0] exp, input [8*8:1] name);
    comparisons = comparisons + 1;
    if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %0h seen %0h", name, exp, got);
    end
endtask
task finish_test;
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
task wait_bit(input integer b, input v);
    integer j;
    for (j = 0; j < 300 && watch[b] !== v; j = j + 1) @(negedge clk);
    if (watch[b] !== v) begin
        n_errors = n_errors + 1;
        finish_test;
    end
endtask
task access(input w, input s, input b32, input [31:0] a);
    @(negedge clk);
    {req_write, req_single, bus32_mode, req_addr, req_valid} = {w, s, b32, a, 1'h1};
    wait_bit(3, 1'h1);
    chk(sdram_write_enable_n, !w, "we");
    chk(sdram_addr, {18'h0, a[12:3]}, "col");
    chk(sdram_bank_select_n, {28'h0, ~(4'h1 << a[29:28])}, "bank");
    chk({low_word_mask, high_word_mask}, w ? {!b32 & a[2], b32 | (s & !a[2])} : 2'h0, "mask");
    req_valid = 1'h0;
    repeat (2) @(negedge clk);
endtask
// ==========================================================
// scenarios
task t_table;
    for (i = 0; i < 16; i = i + 1)
        access(i[0], i[1], i[3], {2'h1, i[1:0], 1'h0, 14'h0155, 10'h0AA, i[2], 2'h0});
    chk(n_write, 16'h8, "writes");
endtask
task t_refused;
    for (k = 0; k < 2; k = k + 1) begin
        @(negedge clk);
        {is_master, req_addr, req_valid, seen} = {k[0], k[0] ? 32'h8000_0000 : 32'h4000_0000, 2'h2};
        repeat (30) @(negedge clk) seen = seen | req_ready;
        chk(seen, 1'h0, "refused");
        if (k == 0) chk(sdram_bank_select_oe_n, 4'hF, "sel_oe");
        req_valid = 1'h0;
    end
    is_master = 1'h1;
endtask
task t_host;
    @(negedge clk) host_bus_request_n = 1'h0;
    wait_bit(2, 1'h1);
    repeat (3) @(negedge clk);
    chk({sdram_clock_enable, sdram_ctl_oe_n, self_refresh}, 3'h3, "handover");
    host_bus_request_n = 1'h1;
    wait_bit(2, 1'h0);
    wait_bit(1, 1'h1);
endtask
task t_suspend;
    @(negedge clk) suspend_req = 1'h1;
    wait_bit(1, 1'h0);
    repeat (5) @(negedge clk);
    chk(sdram_clock_enable, 1'h0, "suspend");
    suspend_req = 1'h0;
    wait_bit(1, 1'h1);
    k = n_refresh;
    repeat (100) @(negedge clk);
    chk(n_refresh - k >= 3, 1'h1, "refresh");
endtask
initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    t_table;
    t_refused;
    t_host;
    t_suspend;
    finish_test;
end
endmodule // sdram_pin_interface_test

// >>> sdram_pin_monitor.sv
`timescale 1ns/1ps
module sdram_pin_monitor #(
    parameter [15:0] REFRESH_INTERVAL = 16'h0618
) (
    input wire clk,
    input wire sys_rst,
    input wire req_write,
    input wire req_single,
    input wire [31:0] req_addr,
    input wire bus32_mode,
    input wire is_master,
    input wire suspend_req,
    input wire req_ready,
    input wire [3:0] sdram_bank_select_n,
    input wire [3:0] sdram_bank_select_oe_n,
    input wire sdram_ras_n,
    input wire sdram_cas_n,
    input wire sdram_write_enable_n,
    input wire sdram_ctl_oe_n,
    input wire sdram_addr_bit10,
    input wire low_word_mask,
    input wire high_word_mask,
    input wire sdram_clock_enable,
    input wire host_bus_grant
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // refresh spacing; restarts while the array sleeps or is handed away
    reg [15:0] gap;
    always @(posedge clk) begin
        if (sys_rst || !sdram_clock_enable || host_bus_grant || (!sdram_ras_n && !sdram_cas_n))
            gap <= 16'h0;
        else
            gap <= gap + 16'h1;
    end
    property p_bank;
        (!sdram_ras_n && sdram_cas_n && sdram_write_enable_n) |->
            sdram_bank_select_n == ~(4'h1 << req_addr[29:28]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");
    property p_release;
        !is_master && $past(!is_master) |-> sdram_bank_select_oe_n == 4'hF;
    endproperty
    a_release: assert property (p_release) else $error("select driven by non-master");
    property p_row_col;
        req_ready |-> sdram_ras_n && !sdram_cas_n && $past(!sdram_ras_n && sdram_cas_n);
    endproperty
    a_row_col: assert property (p_row_col) else $error("row then column order wrong");
    property p_dir;
        req_ready |-> sdram_write_enable_n == !req_write;
    endproperty
    a_dir: assert property (p_dir) else $error("write enable direction wrong");
    property p_gate;
        (low_word_mask || high_word_mask) |-> !sdram_cas_n && !sdram_write_enable_n;
    endproperty
    a_gate: assert property (p_gate) else $error("mask outside write column");
    property p_low;
        req_ready && req_write && !bus32_mode |-> low_word_mask == req_addr[2];
    endproperty
    a_low: assert property (p_low) else $error("low word mask wrong");
    property p_high;
        req_ready && req_write |->
            high_word_mask == (bus32_mode || (req_single && !req_addr[2]));
    endproperty
    a_high: assert property (p_high) else $error("high word mask wrong");
    property p_a10;
        (!sdram_ras_n && sdram_cas_n && !sdram_write_enable_n) |-> sdram_addr_bit10;
    endproperty
    a_a10: assert property (p_a10) else $error("precharge without bit 10");
    property p_suspend;
        $rose(suspend_req) |-> ##[1:8] !sdram_clock_enable;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend not entered");
    property p_host;
        host_bus_grant && $past(host_bus_grant) |->
            !sdram_clock_enable && sdram_ctl_oe_n && sdram_bank_select_oe_n == 4'hF;
    endproperty
    a_host: assert property (p_host) else $error("host handover wrong");
    property p_refresh;
        gap < REFRESH_INTERVAL + 16'h0010;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh overdue");
endmodule // sdram_pin_monitor
bind sdram_pin_interface sdram_pin_monitor #(.REFRESH_INTERVAL(REFRESH_INTERVAL))
    sdram_pin_monitor_i (.*);

// >>> sdram_pins_consts.vh
`ifndef SDRAM_PINS_CONSTS_VH
`define SDRAM_PINS_CONSTS_VH
// ==========================================================
// address decode
`define SDRAM_REGION 2'h1
`define BANK_SEL_MSB 29
`define BANK_SEL_LSB 28
`define RESERVED_MSB 27
// ==========================================================
// refresh timing
`define REFRESH_NS 7800
`define CLK_PERIOD_NS 5
// REFRESH_NS over CLK_PERIOD_NS, held at the parameter width
`define REFRESH_CYCLES 16'h0618
// ==========================================================
// command encodings {ras_n, cas_n, we_n}
`define CMD_NOP 3'h7
`define CMD_ACTIVE 3'h3
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_PRECHARGE 3'h2
`define CMD_REFRESH 3'h1
`define CMD_MODE 3'h0
`endif
